// [hw/timer_gate_control.sv]
// gate control and 16-bit count pair of a general-purpose timer
//
// Notes on behaviour
// - gate enable gates counting only while timer on
// - polarity bit picks the active gate level
// - toggle mode flips gate on each rising edge
// - toggle flip-flop held clear when mode disabled
// - single-pulse mode takes over gating when set
// - status reads one while armed, hardware clears
// - clearing single-pulse mode clears the status
// - gate level bit shows sampled applied gate
// - gate level tracks regardless of gate enable
// - two-bit field selects the gate source
// - low count byte readable and writable
// - high count byte readable and writable
// - reset clears control bits and both count bytes
// - timer off stops counting, clears toggle flop
// - armed pulse counts one gate pulse only
// - falling gate level sets gate event flag
// - count wraps to zero and sets overflow flag
`timescale 1ns/10ps

module timer_gate_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // gate sources and count tick
  input timer_gate_pkg::gate_sources_t gateSources,
  input wire logic countTick,
  // outputs to the rest of the chip
  output logic [15:0] countValue,
  output logic gateLevel,
  output logic irq
);

  // ==========================================================
  // address decode
  function automatic logic isMapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      timer_gate_pkg::OFS_TIMER_CONTROL: hit = 1'b1;
      timer_gate_pkg::OFS_GATE_CONTROL: hit = 1'b1;
      timer_gate_pkg::OFS_COUNT_LOW: hit = 1'b1;
      timer_gate_pkg::OFS_COUNT_HIGH: hit = 1'b1;
      timer_gate_pkg::OFS_INT_STATUS: hit = 1'b1;
      timer_gate_pkg::OFS_INT_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] gateControlWord(
    input timer_gate_pkg::state_t s
  );
    logic [7:0] w;
    w = timer_gate_pkg::RST_BYTE;
    w[timer_gate_pkg::GC_ENABLE] = s.gateEnable;
    w[timer_gate_pkg::GC_POLARITY] = s.gatePolarity;
    w[timer_gate_pkg::GC_TOGGLE] = s.gateToggleMode;
    w[timer_gate_pkg::GC_SINGLE] = s.singlePulseMode;
    w[timer_gate_pkg::GC_STATUS] = s.pulseAcquireStatus;
    w[timer_gate_pkg::GC_LEVEL] = s.gateLevel;
    w[timer_gate_pkg::GC_SEL_LO+:2] = s.gateSourceSelect;
    return w;
  endfunction

  // ==========================================================
  // state
  timer_gate_pkg::state_t state_q;
  timer_gate_pkg::state_t state_d;

  logic setupPhase;
  logic writeAccess;
  logic readSetup;
  logic timerOn;
  logic selected;
  logic polarized;
  logic toggled;
  logic togRise;
  logic togFall;
  logic applied;
  logic gateFall;
  logic countWrite;
  logic countEnable;
  logic [15:0] countNow;
  logic [15:0] countNext;
  localparam int INT_BITS_W = timer_gate_pkg::INT_BITS;
  logic [INT_BITS_W-1:0] events;

  assign setupPhase = psel && !penable;
  assign readSetup = setupPhase && !pwrite;
  assign writeAccess = psel && penable && pwrite && isMapped(paddr);
  assign timerOn = state_q.timerControl[timer_gate_pkg::TC_TIMER_ON];
  assign countNow = {state_q.countHigh, state_q.countLow};

  // ==========================================================
  // gate source and polarity
  always_comb begin
    case (state_q.gateSourceSelect)
      timer_gate_pkg::SEL_CMP2: selected = gateSources.cmp2Out;
      timer_gate_pkg::SEL_CMP1: selected = gateSources.cmp1Out;
      timer_gate_pkg::SEL_TMR0: selected = gateSources.tmr0Overflow;
      timer_gate_pkg::SEL_PIN: selected = gateSources.gatePin;
      default: selected = gateSources.gatePin;
    endcase
  end

  // active level high when polarity set, low when clear
  assign polarized = state_q.gatePolarity ? selected : !selected;

  // ==========================================================
  // toggle and single-pulse stages
  assign toggled = state_q.gateToggleMode ? state_q.toggleFf : polarized;
  assign togRise = toggled && !state_q.togPrev;
  assign togFall = !toggled && state_q.togPrev;

  always_comb begin
    applied = toggled;
    if (state_q.singlePulseMode) begin
      case (state_q.pulseState)
        timer_gate_pkg::SP_WAIT: applied = togRise;
        timer_gate_pkg::SP_RUN: applied = toggled;
        timer_gate_pkg::SP_IDLE: applied = 1'b0;
        default: applied = 1'b0;
      endcase
    end
  end

  assign gateFall = state_q.gateLevel && !applied;

  // gate enable only matters while the timer runs
  assign countEnable = timerOn && countTick &&
                       (!state_q.gateEnable || state_q.gateLevel);
  assign countWrite = writeAccess &&
                      (paddr == timer_gate_pkg::OFS_COUNT_LOW ||
                       paddr == timer_gate_pkg::OFS_COUNT_HIGH);
  assign countNext = countNow + 16'h0001;

  always_comb begin
    events = '0;
    events[timer_gate_pkg::INT_OVERFLOW] = countEnable && !countWrite &&
      (countNow == timer_gate_pkg::COUNT_MAX);
    events[timer_gate_pkg::INT_GATE_EVENT] = gateFall;
  end

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;

    // edge history for the toggle and pulse stages
    state_d.polPrev = polarized;
    state_d.togPrev = toggled;

    // toggle flip-flop
    if (!state_q.gateToggleMode || !timerOn) begin
      state_d.toggleFf = 1'b0;
    end else if (polarized && !state_q.polPrev) begin
      state_d.toggleFf = !state_q.toggleFf;
    end

    // sampled applied gate, kept whatever gate enable says
    state_d.gateLevel = applied;

    // single-pulse sequencer
    case (state_q.pulseState)
      timer_gate_pkg::SP_IDLE: begin
        if (state_q.pulseAcquireStatus && state_q.singlePulseMode) begin
          state_d.pulseState = timer_gate_pkg::SP_WAIT;
        end
      end
      timer_gate_pkg::SP_WAIT: begin
        if (togRise) begin
          state_d.pulseState = timer_gate_pkg::SP_RUN;
        end
      end
      timer_gate_pkg::SP_RUN: begin
        if (togFall) begin
          state_d.pulseState = timer_gate_pkg::SP_IDLE;
          state_d.pulseAcquireStatus = 1'b0;
        end
      end
      default: state_d.pulseState = timer_gate_pkg::SP_IDLE;
    endcase

    // counter
    if (countEnable) begin
      state_d.countLow = countNext[7:0];
      state_d.countHigh = countNext[15:8];
    end

    // sticky interrupt flags, set wins over a clear below
    state_d.intStatus = state_q.intStatus | events;

    // register writes
    if (writeAccess) begin
      case (paddr)
        timer_gate_pkg::OFS_TIMER_CONTROL: begin
          state_d.timerControl = pwdata[7:0];
          state_d.timerControl[timer_gate_pkg::TC_UNIMPL] = 1'b0;
        end
        timer_gate_pkg::OFS_GATE_CONTROL: begin
          state_d.gateEnable = pwdata[timer_gate_pkg::GC_ENABLE];
          state_d.gatePolarity = pwdata[timer_gate_pkg::GC_POLARITY];
          state_d.gateToggleMode = pwdata[timer_gate_pkg::GC_TOGGLE];
          state_d.singlePulseMode = pwdata[timer_gate_pkg::GC_SINGLE];
          state_d.pulseAcquireStatus = pwdata[timer_gate_pkg::GC_STATUS] &&
            pwdata[timer_gate_pkg::GC_SINGLE];
          state_d.gateSourceSelect =
            pwdata[timer_gate_pkg::GC_SEL_LO+:2];
          if (!pwdata[timer_gate_pkg::GC_STATUS] ||
              !pwdata[timer_gate_pkg::GC_SINGLE]) begin
            state_d.pulseState = timer_gate_pkg::SP_IDLE;
          end
        end
        timer_gate_pkg::OFS_COUNT_LOW: begin
          state_d.countLow = pwdata[7:0];
          state_d.countHigh = state_q.countHigh;
        end
        timer_gate_pkg::OFS_COUNT_HIGH: begin
          state_d.countHigh = pwdata[7:0];
          state_d.countLow = state_q.countLow;
        end
        timer_gate_pkg::OFS_INT_STATUS: begin
          for (int i = 0; i < INT_BITS_W; i++) begin
            if (pwdata[i] && !events[i]) begin
              state_d.intStatus[i] = 1'b0;
            end
          end
        end
        timer_gate_pkg::OFS_INT_MASK: begin
          state_d.intMask = pwdata[INT_BITS_W-1:0];
        end
        default: state_d.intMask = state_q.intMask;
      endcase
    end

    // read data captured in the setup phase
    if (readSetup) begin
      case (paddr)
        timer_gate_pkg::OFS_TIMER_CONTROL:
          state_d.readData = {24'h000000, state_q.timerControl};
        timer_gate_pkg::OFS_GATE_CONTROL:
          state_d.readData = {24'h000000, gateControlWord(state_q)};
        timer_gate_pkg::OFS_COUNT_LOW:
          state_d.readData = {24'h000000, state_q.countLow};
        timer_gate_pkg::OFS_COUNT_HIGH:
          state_d.readData = {24'h000000, state_q.countHigh};
        timer_gate_pkg::OFS_INT_STATUS:
          state_d.readData = {30'h00000000, state_q.intStatus};
        timer_gate_pkg::OFS_INT_MASK:
          state_d.readData = {30'h00000000, state_q.intMask};
        default: state_d.readData = timer_gate_pkg::RST_WORD;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      // power-on and brown-out reset clears all control bits
      state_q.timerControl <= timer_gate_pkg::RST_BYTE;
      state_q.gateEnable <= 1'b0;
      state_q.gatePolarity <= 1'b0;
      state_q.gateToggleMode <= 1'b0;
      state_q.singlePulseMode <= 1'b0;
      state_q.pulseAcquireStatus <= 1'b0;
      state_q.gateSourceSelect <= timer_gate_pkg::RST_SEL;
      state_q.polPrev <= 1'b0;
      state_q.toggleFf <= 1'b0;
      state_q.togPrev <= 1'b0;
      state_q.gateLevel <= 1'b0;
      state_q.pulseState <= timer_gate_pkg::SP_IDLE;
      state_q.countLow <= timer_gate_pkg::RST_BYTE;
      state_q.countHigh <= timer_gate_pkg::RST_BYTE;
      state_q.intStatus <= timer_gate_pkg::RST_INT;
      state_q.intMask <= timer_gate_pkg::RST_INT;
      state_q.readData <= timer_gate_pkg::RST_WORD;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = state_q.readData;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);
  assign countValue = countNow;
  assign gateLevel = state_q.gateLevel;
  assign irq = |(state_q.intStatus & state_q.intMask);

endmodule

// [hw/timer_gate_pkg.sv]
// constants, types and register map of the timer gate control block
package timer_gate_pkg;

  // ==========================================================
  // register map, byte addresses on the apb bus
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_GATE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;

  // ==========================================================
  // field positions
  localparam int TC_TIMER_ON = 0;
  localparam int TC_UNIMPL = 1;
  localparam int GC_ENABLE = 7;
  localparam int GC_POLARITY = 6;
  localparam int GC_TOGGLE = 5;
  localparam int GC_SINGLE = 4;
  localparam int GC_STATUS = 3;
  localparam int GC_LEVEL = 2;
  localparam int GC_SEL_LO = 0;
  localparam int INT_OVERFLOW = 0;
  localparam int INT_GATE_EVENT = 1;
  localparam int INT_BITS = 2;

  // ==========================================================
  // gate source select codes
  localparam logic [1:0] SEL_PIN = 2'h0;
  localparam logic [1:0] SEL_TMR0 = 2'h1;
  localparam logic [1:0] SEL_CMP1 = 2'h2;
  localparam logic [1:0] SEL_CMP2 = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [INT_BITS-1:0] RST_INT = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_WAIT = 3'b010,
    SP_RUN = 3'b100
  } pulse_state_t;

  typedef struct packed {
    logic cmp2Out;
    logic cmp1Out;
    logic tmr0Overflow;
    logic gatePin;
  } gate_sources_t;

  typedef struct packed {
    logic [7:0] timerControl;
    logic gateEnable;
    logic gatePolarity;
    logic gateToggleMode;
    logic singlePulseMode;
    logic pulseAcquireStatus;
    logic [1:0] gateSourceSelect;
    logic polPrev;
    logic toggleFf;
    logic togPrev;
    logic gateLevel;
    pulse_state_t pulseState;
    logic [7:0] countLow;
    logic [7:0] countHigh;
    logic [INT_BITS-1:0] intStatus;
    logic [INT_BITS-1:0] intMask;
    logic [31:0] readData;
  } state_t;

endpackage

// [tb/gate_source_model.sv]
// model of the gate sources and count clock feeding the timer
`timescale 1ns/10ps
module gate_source_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic [3:0] levelReq,
  input wire logic tickReq,
  // toward the timer
  output timer_gate_pkg::gate_sources_t gateSources,
  output logic countTick
);
  // sources move only on the clock, as synchronous levels
  always_ff @(posedge clk) begin
    gateSources <= timer_gate_pkg::gate_sources_t'(levelReq);
    countTick <= tickReq;
  end
endmodule

// [tb/timer_gate_checker.sv]
// port assertions of the timer gate control block
`timescale 1ns/10ps
module timer_gate_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // gate and count
  input timer_gate_pkg::gate_sources_t gateSources,
  input wire logic countTick,
  input wire logic [15:0] countValue,
  input wire logic gateLevel,
  input wire logic irq
);
  logic wrAcc;
  logic rdSet;
  logic mapped;
  assign wrAcc = psel && penable && pwrite;
  assign rdSet = psel && !penable && !pwrite;
  assign mapped = paddr <= 8'h14 && paddr[1:0] == 2'h0;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ====
  // bus answers
  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_unmapped_zero: assert property (rdSet && !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_level_read: assert property (
    rdSet && paddr == 8'h04 |=> prdata[2] == $past(gateLevel))
    else $error("level bit wrong");
  a_count_read: assert property (
    rdSet && paddr == 8'h08 |=> prdata == {24'h0, $past(countValue[7:0])})
    else $error("low byte read wrong");

  // ====
  // count behaviour
  a_hold_count: assert property (
    !countTick && !wrAcc |=> $stable(countValue))
    else $error("count moved without tick");
  a_step_count: assert property (
    countTick && !wrAcc |=> $stable(countValue)
      || countValue == $past(countValue) + 16'h1)
    else $error("count step wrong");
  a_low_write: assert property (
    wrAcc && paddr == 8'h08 |=> countValue[7:0] == $past(pwdata[7:0]))
    else $error("low byte write lost");
  a_high_write: assert property (
    wrAcc && paddr == 8'h0C |=> countValue[15:8] == $past(pwdata[7:0]))
    else $error("high byte write lost");
endmodule

bind timer_gate_control timer_gate_checker u_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gateSources(gateSources),
  .countTick(countTick), .countValue(countValue),
  .gateLevel(gateLevel), .irq(irq));

// [tb/timer_gate_control_bench.sv]
// self-checking bench of the timer gate control block
`timescale 1ns/10ps
module timer_gate_control_bench;
  localparam logic [7:0] TC = timer_gate_pkg::OFS_TIMER_CONTROL;
  localparam logic [7:0] GC = timer_gate_pkg::OFS_GATE_CONTROL;
  localparam logic [7:0] LO = timer_gate_pkg::OFS_COUNT_LOW;
  localparam logic [7:0] HI = timer_gate_pkg::OFS_COUNT_HIGH;
  localparam logic [7:0] IS = timer_gate_pkg::OFS_INT_STATUS;
  localparam logic [7:0] IM = timer_gate_pkg::OFS_INT_MASK;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic [3:0] levelReq = 4'hF;
  logic tickReq = 1'b0;
  timer_gate_pkg::gate_sources_t gateSources;
  logic countTick;
  logic [15:0] countValue;
  logic gateLevel;
  logic irq;
  logic [31:0] r;
  logic [15:0] expCnt = 16'hFFFE;
  int errorCnt = 0;
  int checkCount = 0;

  always #12.5 clk = ~clk;

  gate_source_model u_src (.clk(clk), .levelReq(levelReq),
    .tickReq(tickReq), .gateSources(gateSources), .countTick(countTick));
  timer_gate_control u_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(),
    .gateSources(gateSources), .countTick(countTick),
    .countValue(countValue), .gateLevel(gateLevel), .irq(irq));

  // ====
  // tasks
  task automatic endOfTest;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errorCnt++;
      endOfTest();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task automatic lv(input logic [3:0] v);
    @(posedge clk);
    levelReq <= v;
    repeat (4) @(posedge clk);
  endtask

  // irq is decoded from the flopped status and mask bits, so it is read one edge after the access
  task automatic ir(input logic e);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // two ticks, then the count is read back
  task automatic tk(input logic [15:0] n);
    @(posedge clk);
    tickReq <= 1'b1;
    repeat (2) @(posedge clk);
    tickReq <= 1'b0;
    repeat (3) @(posedge clk);
    expCnt = expCnt + n;
    rd(LO, {24'h0, expCnt[7:0]});
    rd(HI, {24'h0, expCnt[15:8]});
  endtask

  // ====
  // sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rd(8'(4 * a), 32'h0);
    end
    wr(LO, 32'hFE);
    wr(HI, 32'hFF);
    rd(LO, 32'hFE);
    rd(HI, 32'hFF);
    wr(TC, 32'h1);
    tk(2);
    rd(IS, 32'h1);
    ir(1'b0);
    wr(IM, 32'h3);
    ir(1'b1);
    wr(IS, 32'h1);
    ir(1'b0);
    wr(GC, 32'h40);
    lv(4'h1);
    rd(GC, 32'h44);
    lv(4'h0);
    rd(IS, 32'h2);
    ir(1'b1);
    tk(2);
    wr(IS, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(GC, 32'hC0 | i);
      lv(~(4'h1 << i));
      tk(0);
      lv(4'h1 << i);
      tk(2);
    end
    wr(GC, 32'h80);
    lv(4'h0);
    tk(2);
    lv(4'hF);
    tk(0);
    lv(4'h0);
    wr(GC, 32'hE0);
    lv(4'h1);
    lv(4'h0);
    rd(GC, 32'hE4);
    tk(2);
    lv(4'h1);
    lv(4'h0);
    tk(0);
    lv(4'h1);
    lv(4'h0);
    wr(TC, 32'h0);
    tk(0);
    wr(TC, 32'h1);
    rd(GC, 32'hE0);
    lv(4'h1);
    lv(4'h0);
    wr(GC, 32'hC0);
    wr(GC, 32'hE0);
    rd(GC, 32'hE0);
    wr(GC, 32'hD8);
    rd(GC, 32'hD8);
    lv(4'h1);
    tk(2);
    lv(4'h0);
    rd(GC, 32'hD0);
    lv(4'h1);
    tk(0);
    lv(4'h0);
    wr(GC, 32'hD8);
    wr(GC, 32'hC8);
    rd(GC, 32'hC0);
    // high byte written while ticks run: the write edge does not count
    wr(GC, 32'h0);
    tickReq <= 1'b1;
    wr(HI, 32'h34);
    tickReq <= 1'b0;
    repeat (3) @(posedge clk);
    rd(LO, 32'h12);
    rd(HI, 32'h34);
    endOfTest();
  end
endmodule
